// *** src/opmode_pkg.sv ***
// Purpose: shared constants and types of the operating mode controller
// Assumes: 10 MHz system clock, one clock domain
// Notes: pin widths are fixed; settle time is a least time, rounded up
package opmode_pkg;

	// widths of the wake source groups
	localparam int PORTA_W = 8;
	localparam int IRQ_W = 8;

	// clock select codes
	localparam logic [2:0] SEL_SUB = 3'h7;
	localparam logic [2:0] SEL_RESET = 3'h0;
	localparam logic [1:0] HS_FREQ_RESET = 2'h0;

	// reset values of the flags and idle level of port a pins
	localparam logic PDF_RESET = 1'b0;
	localparam logic TOF_RESET = 1'b0;
	localparam logic [PORTA_W-1:0] PORTA_IDLE = 8'hff;
	localparam logic [IRQ_W-1:0] IRQ_NONE = 8'h00;

	// high-speed oscillator settle time after enable or frequency change
	localparam int CLK_PERIOD_NS = 100;
	localparam int HS_SETTLE_NS = 16000;
	localparam int HS_SETTLE_CYCLES = (HS_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETTLE_W = 8;
	localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(HS_SETTLE_CYCLES);

	// operating states
	typedef enum logic [3:0] {
		st_fast,
		st_to_slow,
		st_slow,
		st_to_fast,
		st_sleep,
		st_idle_subclk_only,
		st_idle_both_clocks,
		st_idle_hsclk_only
	} op_state_t;

endpackage

// *** src/pin_sync3.sv ***
// Purpose: three-stage synchroniser with agreement filter for async inputs
// Assumes: inputs come from outside the clk_sys_in domain
// Notes: output moves only once the second and third stages agree
`timescale 1ns/100ps
module pin_sync3 #(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	// raw and filtered levels
	input wire logic [W-1:0] raw_in,
	output logic [W-1:0] clean_out
);

	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;
	wire logic [W-1:0] agree = ~(s2 ^ s3);

	// stage chain; first stage feeds only the second
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			s1 <= RST;
			s2 <= RST;
			s3 <= RST;
			clean_out <= RST;
		end else begin
			s1 <= raw_in;
			s2 <= s1;
			s3 <= s2;
			clean_out <= (s2 & agree) | (clean_out & ~agree);
		end
	end

endmodule

// *** src/operating_mode_power_controller.sv ***
// Purpose: fast/slow clock switching, halt into sleep or idle, and wake-up
// Assumes: cpu core holds registers, memory and ports frozen while cpu_run_out is low
// Notes: watchdog counter and interrupt flags live outside; this block steers them
//
// Behaviour
// - select code 111 in fast operation moves system clock to the sub clock.
// - switch into slow completes only once the low-speed oscillator is stable.
// - codes 000 to 110 return to fast, system clock high-speed divided 1 to 64.
// - return to fast waits for high-speed oscillator restabilisation, shown by stable flag.
// - halt with both idle enables low enters sleep; only watchdog keeps running.
// - halt with hs enable low, ls enable high enters sub-clock-only idle.
// - halt with both idle enables high enters idle with both clocks running.
// - halt with hs enable high, ls enable low enters high-speed-only idle.
// - sleep or idle stops program at halt, all state retained.
// - halt sets the power-down flag and clears the watchdog timeout flag.
// - entering sleep or idle clears the watchdog counter, which keeps counting.
// - wake on enabled port a falling edge, system interrupt or watchdog overflow.
// - power-down flag clears only on power-up or clear-watchdog instruction.
// - watchdog wake sets timeout flag, resets only program counter and stack pointer.
// - per-pin mask enables port a wake; execution resumes after halt.
// - disabled waking interrupt or full stack resumes after halt; interrupt stays pending.
// - enabled waking interrupt with stack not full gets the normal interrupt response.
// - interrupt flagged before halt cannot wake the device.
// - stable flag clears on enable or frequency change, sets after settling.
// - low-speed oscillator stays on during halt while the watchdog is enabled.
`timescale 1ns/100ps
module operating_mode_power_controller (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	// cpu core
	input wire logic halt_in,
	input wire logic wdt_clear_instr_in,
	input wire logic stack_full_in,
	// clock control bits
	input wire logic [2:0] sysclk_select_in,
	input wire logic hs_osc_idle_enable_in,
	input wire logic ls_osc_idle_enable_in,
	input wire logic hs_osc_enable_in,
	input wire logic [1:0] hs_freq_select_in,
	input wire logic wdt_enable_in,
	// oscillator ready levels, asynchronous
	input wire logic hs_osc_ready_in,
	input wire logic ls_osc_ready_in,
	// wake sources
	input wire logic [opmode_pkg::PORTA_W-1:0] porta_in,
	input wire logic [opmode_pkg::PORTA_W-1:0] porta_wake_mask_in,
	input wire logic [opmode_pkg::IRQ_W-1:0] irq_request_in,
	input wire logic [opmode_pkg::IRQ_W-1:0] irq_enable_in,
	input wire logic wdt_overflow_in,
	// clock steering
	output logic sysclk_use_sub_out,
	output logic [2:0] sysclk_div_sel_out,
	output logic [1:0] hs_freq_out,
	output logic hs_osc_en_out,
	output logic ls_osc_en_out,
	output logic hs_clk_run_out,
	output logic sub_clk_run_out,
	output logic cpu_run_out,
	// status flags
	output logic hs_osc_stable_flag_out,
	output logic powerdown_flag_out,
	output logic wdt_timeout_flag_out,
	// one-cycle actions
	output logic wdt_counter_clear_out,
	output logic wake_resume_out,
	output logic wake_irq_response_out,
	output logic pc_sp_reset_out,
	// current state
	output logic [3:0] op_state_out
);

	opmode_pkg::op_state_t state;
	opmode_pkg::op_state_t next_state;
	opmode_pkg::op_state_t halt_target;

	logic resume_slow;
	logic [opmode_pkg::PORTA_W-1:0] porta_prev;
	logic [opmode_pkg::IRQ_W-1:0] irq_before_halt;
	logic [opmode_pkg::SETTLE_W-1:0] settle_cnt;
	logic [1:0] freq_seen;
	logic next_hs_en;
	logic next_ls_en;

	wire logic [opmode_pkg::PORTA_W-1:0] porta_clean;
	wire logic [1:0] ready_clean;

	// synchronise port a pins
	pin_sync3 #(
		.W(opmode_pkg::PORTA_W),
		.RST(opmode_pkg::PORTA_IDLE)
	) u_porta_sync (
		.clk_sys_in(clk_sys_in),
		.resetn_in(resetn_in),
		.raw_in(porta_in),
		.clean_out(porta_clean)
	);

	// synchronise oscillator ready levels
	pin_sync3 #(
		.W(2),
		.RST(2'h0)
	) u_ready_sync (
		.clk_sys_in(clk_sys_in),
		.resetn_in(resetn_in),
		.raw_in({hs_osc_ready_in, ls_osc_ready_in}),
		.clean_out(ready_clean)
	);

	wire logic hs_ready = ready_clean[1];
	wire logic ls_ready = ready_clean[0];

	// state classes
	wire logic in_run = (state == opmode_pkg::st_fast) || (state == opmode_pkg::st_slow);
	wire logic in_low_power = (state == opmode_pkg::st_sleep) ||
		(state == opmode_pkg::st_idle_subclk_only) ||
		(state == opmode_pkg::st_idle_both_clocks) ||
		(state == opmode_pkg::st_idle_hsclk_only);
	wire logic sel_is_sub = (sysclk_select_in == opmode_pkg::SEL_SUB);

	// halt is taken only while the program runs
	wire logic halt_take = halt_in && in_run;
	wire logic [1:0] idle_pair = {hs_osc_idle_enable_in, ls_osc_idle_enable_in};

	// wake sources
	wire logic [opmode_pkg::PORTA_W-1:0] porta_fall =
		porta_prev & ~porta_clean & porta_wake_mask_in;
	wire logic [opmode_pkg::IRQ_W-1:0] irq_new = irq_request_in & ~irq_before_halt;
	wire logic wake_port = |porta_fall;
	wire logic wake_irq = |irq_new;
	wire logic wake_any = in_low_power && (wake_port || wake_irq || wdt_overflow_in);
	wire logic irq_serviceable = (|(irq_new & irq_enable_in)) && !stack_full_in;

	// stable flag restarts on enable rise or frequency change
	wire logic hs_restart = (next_hs_en && !hs_osc_en_out) ||
		(hs_freq_select_in != freq_seen);
	wire logic settle_done = (settle_cnt == opmode_pkg::SETTLE_LAST);

	// low-power mode chosen from the idle enable pair
	always_comb begin
		case (idle_pair)
			2'b00: halt_target = opmode_pkg::st_sleep;
			2'b01: halt_target = opmode_pkg::st_idle_subclk_only;
			2'b11: halt_target = opmode_pkg::st_idle_both_clocks;
			2'b10: halt_target = opmode_pkg::st_idle_hsclk_only;
			default: halt_target = opmode_pkg::st_sleep;
		endcase
	end

	// next operating state
	always_comb begin
		next_state = state;
		case (state)
			opmode_pkg::st_fast: begin
				if (halt_take) begin
					next_state = halt_target;
				end else if (sel_is_sub) begin
					next_state = opmode_pkg::st_to_slow;
				end
			end
			opmode_pkg::st_to_slow: begin
				if (!sel_is_sub) begin
					next_state = opmode_pkg::st_fast;
				end else if (ls_ready) begin
					next_state = opmode_pkg::st_slow;
				end
			end
			opmode_pkg::st_slow: begin
				if (halt_take) begin
					next_state = halt_target;
				end else if (!sel_is_sub) begin
					next_state = opmode_pkg::st_to_fast;
				end
			end
			opmode_pkg::st_to_fast: begin
				if (sel_is_sub) begin
					next_state = opmode_pkg::st_slow;
				end else if (hs_osc_stable_flag_out) begin
					next_state = opmode_pkg::st_fast;
				end
			end
			opmode_pkg::st_sleep,
			opmode_pkg::st_idle_subclk_only,
			opmode_pkg::st_idle_both_clocks,
			opmode_pkg::st_idle_hsclk_only: begin
				if (wake_any) begin
					next_state = resume_slow ? opmode_pkg::st_slow : opmode_pkg::st_to_fast;
				end
			end
			default: next_state = opmode_pkg::st_fast;
		endcase
	end

	// oscillator enables follow the next state
	always_comb begin
		case (next_state)
			opmode_pkg::st_fast,
			opmode_pkg::st_to_fast,
			opmode_pkg::st_to_slow: begin
				next_hs_en = 1'b1;
				next_ls_en = 1'b1;
			end
			opmode_pkg::st_slow: begin
				next_hs_en = hs_osc_enable_in;
				next_ls_en = 1'b1;
			end
			opmode_pkg::st_sleep: begin
				next_hs_en = 1'b0;
				next_ls_en = wdt_enable_in;
			end
			opmode_pkg::st_idle_subclk_only: begin
				next_hs_en = 1'b0;
				next_ls_en = 1'b1;
			end
			opmode_pkg::st_idle_both_clocks: begin
				next_hs_en = 1'b1;
				next_ls_en = 1'b1;
			end
			opmode_pkg::st_idle_hsclk_only: begin
				next_hs_en = 1'b1;
				next_ls_en = wdt_enable_in;
			end
			default: begin
				next_hs_en = 1'b1;
				next_ls_en = 1'b1;
			end
		endcase
	end

	// clock gates and cpu run, decoded from the next state
	wire logic next_low_power = (next_state == opmode_pkg::st_sleep) ||
		(next_state == opmode_pkg::st_idle_subclk_only) ||
		(next_state == opmode_pkg::st_idle_both_clocks) ||
		(next_state == opmode_pkg::st_idle_hsclk_only);
	wire logic next_sub_run = (next_state != opmode_pkg::st_sleep) &&
		(next_state != opmode_pkg::st_idle_hsclk_only);
	wire logic next_use_sub = (next_state == opmode_pkg::st_slow) ||
		(next_state == opmode_pkg::st_to_fast);

	// state register and resume memory
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state <= opmode_pkg::st_fast;
			resume_slow <= 1'b0;
		end else begin
			state <= next_state;
			if (halt_take) begin
				resume_slow <= (state == opmode_pkg::st_slow);
			end
		end
	end

	// clock steering outputs
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			sysclk_use_sub_out <= 1'b0;
			sysclk_div_sel_out <= opmode_pkg::SEL_RESET;
			hs_osc_en_out <= 1'b1;
			ls_osc_en_out <= 1'b1;
			hs_clk_run_out <= 1'b0;
			sub_clk_run_out <= 1'b1;
			cpu_run_out <= 1'b1;
			op_state_out <= 4'h0;
		end else begin
			sysclk_use_sub_out <= next_use_sub;
			if (next_state == opmode_pkg::st_fast) begin
				sysclk_div_sel_out <= sysclk_select_in;
			end
			hs_osc_en_out <= next_hs_en;
			ls_osc_en_out <= next_ls_en;
			hs_clk_run_out <= next_hs_en && hs_osc_stable_flag_out;
			sub_clk_run_out <= next_sub_run;
			cpu_run_out <= !next_low_power;
			op_state_out <= next_state;
		end
	end

	// high-speed settle counter and stable flag
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			settle_cnt <= '0;
			freq_seen <= opmode_pkg::HS_FREQ_RESET;
			hs_freq_out <= opmode_pkg::HS_FREQ_RESET;
			hs_osc_stable_flag_out <= 1'b0;
		end else begin
			freq_seen <= hs_freq_select_in;
			if (!next_hs_en || hs_restart) begin
				settle_cnt <= '0;
				hs_osc_stable_flag_out <= 1'b0;
			end else begin
				if (hs_ready && !settle_done) begin
					settle_cnt <= settle_cnt + 1'b1;
				end
				hs_osc_stable_flag_out <= settle_done;
			end
			if (hs_osc_stable_flag_out) begin
				hs_freq_out <= freq_seen;
			end
		end
	end

	// power-down and timeout flags; a set beats a clear in the same cycle
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			powerdown_flag_out <= opmode_pkg::PDF_RESET;
			wdt_timeout_flag_out <= opmode_pkg::TOF_RESET;
		end else begin
			if (halt_take) begin
				powerdown_flag_out <= 1'b1;
			end else if (wdt_clear_instr_in) begin
				powerdown_flag_out <= 1'b0;
			end
			if (wdt_overflow_in) begin
				wdt_timeout_flag_out <= 1'b1;
			end else if (halt_take) begin
				wdt_timeout_flag_out <= 1'b0;
			end
		end
	end

	// wake source history
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			porta_prev <= opmode_pkg::PORTA_IDLE;
			irq_before_halt <= opmode_pkg::IRQ_NONE;
		end else begin
			porta_prev <= porta_clean;
			if (halt_take) begin
				irq_before_halt <= irq_request_in;
			end
		end
	end

	// one-cycle action pulses
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			wdt_counter_clear_out <= 1'b0;
			wake_resume_out <= 1'b0;
			wake_irq_response_out <= 1'b0;
			pc_sp_reset_out <= 1'b0;
		end else begin
			wdt_counter_clear_out <= halt_take || wdt_clear_instr_in;
			pc_sp_reset_out <= wake_any && wdt_overflow_in;
			wake_irq_response_out <= wake_any && !wdt_overflow_in &&
				wake_irq && irq_serviceable;
			wake_resume_out <= wake_any && !wdt_overflow_in &&
				!(wake_irq && irq_serviceable);
		end
	end

endmodule

// *** test/opmode_checker.sv ***
// Purpose: concurrent checks on the operating mode controller ports
// Assumes: single clock domain, async active-low reset
// Notes: state codes 4 to 7 are the low power modes
`timescale 1ns/100ps
module opmode_checker (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	// watched inputs
	input wire logic halt_in,
	input wire logic wdt_clear_instr_in,
	input wire logic [2:0] sysclk_select_in,
	input wire logic hs_osc_idle_enable_in,
	input wire logic ls_osc_idle_enable_in,
	input wire logic [1:0] hs_freq_select_in,
	input wire logic wdt_enable_in,
	input wire logic ls_osc_ready_in,
	input wire logic wdt_overflow_in,
	// watched outputs
	input wire logic sysclk_use_sub_out,
	input wire logic ls_osc_en_out,
	input wire logic sub_clk_run_out,
	input wire logic cpu_run_out,
	input wire logic hs_osc_stable_flag_out,
	input wire logic powerdown_flag_out,
	input wire logic wdt_timeout_flag_out,
	input wire logic wdt_counter_clear_out,
	input wire logic pc_sp_reset_out,
	input wire logic [3:0] op_state_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!resetn_in);

	// halt accepted in fast or slow only; low power is codes 4 to 7
	wire logic take = halt_in && (op_state_out == 4'h0 || op_state_out == 4'h2);
	wire logic low = op_state_out[2];
	wire logic [1:0] pair = {hs_osc_idle_enable_in, ls_osc_idle_enable_in};

	property p_mode;
		take |=> op_state_out == {2'h1, $past(pair[1]), $past(^pair)} && sub_clk_run_out == $past(pair[0]);
	endproperty
	a_mode: assert property (p_mode) else $error("wrong low power mode");
	property p_flags;
		take && !wdt_overflow_in |=> powerdown_flag_out && !wdt_timeout_flag_out && wdt_counter_clear_out;
	endproperty
	a_flags: assert property (p_flags) else $error("halt flags wrong");
	property p_run;
		low |-> !cpu_run_out;
	endproperty
	a_run: assert property (p_run) else $error("cpu runs in low power");
	property p_to_slow;
		op_state_out == 4'h0 && sysclk_select_in == 3'h7 && !halt_in |=> op_state_out == 4'h1;
	endproperty
	a_to_slow: assert property (p_to_slow) else $error("no move towards slow");
	property p_ls_ok;
		op_state_out == 4'h2 && $past(op_state_out) == 4'h1 |-> $past(ls_osc_ready_in, 2) && sysclk_use_sub_out;
	endproperty
	a_ls_ok: assert property (p_ls_ok) else $error("slow before sub clock ready");
	property p_pdf;
		$fell(powerdown_flag_out) |-> $past(wdt_clear_instr_in);
	endproperty
	a_pdf: assert property (p_pdf) else $error("power-down flag cleared");
	property p_wdt_wake;
		low && wdt_overflow_in |=> pc_sp_reset_out && wdt_timeout_flag_out && cpu_run_out;
	endproperty
	a_wdt_wake: assert property (p_wdt_wake) else $error("watchdog wake wrong");
	property p_stable;
		hs_freq_select_in != $past(hs_freq_select_in) |=> !hs_osc_stable_flag_out;
	endproperty
	a_stable: assert property (p_stable) else $error("stable flag held");
	property p_ls_wdt;
		low && $past(low) && $past(wdt_enable_in) |-> ls_osc_en_out;
	endproperty
	a_ls_wdt: assert property (p_ls_wdt) else $error("sub osc off with watchdog");

	// main scenarios reached
	c_sleep: cover property (take && pair == 2'h0);
	c_wdt_wake: cover property (low && wdt_overflow_in);
	c_slow: cover property (op_state_out == 4'h2);
endmodule

bind operating_mode_power_controller opmode_checker u_chk (.clk_sys_in, .resetn_in, .halt_in,
	.wdt_clear_instr_in, .sysclk_select_in, .hs_osc_idle_enable_in, .ls_osc_idle_enable_in,
	.hs_freq_select_in, .wdt_enable_in, .ls_osc_ready_in, .wdt_overflow_in, .sysclk_use_sub_out,
	.ls_osc_en_out, .sub_clk_run_out, .cpu_run_out, .hs_osc_stable_flag_out,
	.powerdown_flag_out, .wdt_timeout_flag_out, .wdt_counter_clear_out, .pc_sp_reset_out,
	.op_state_out);

// *** test/osc_model.sv ***
// Purpose: behavioural high- and low-speed oscillators behind the controller
// Assumes: ready follows enable after a start-up count
// Notes: slow_in stretches start-up to exercise waiting
`timescale 1ns/100ps
module osc_model (
	// clock
	input wire logic clk_sys_in,
	// enables and speed
	input wire logic hs_en_in,
	input wire logic ls_en_in,
	input wire logic slow_in,
	// ready levels
	output logic hs_ready_out = 1'b0,
	output logic ls_ready_out = 1'b0
);
	int hs_cnt = 0;
	int ls_cnt = 0;

	// ready drops at once on disable, rises after start-up
	always @(negedge clk_sys_in) begin
		hs_cnt = hs_en_in ? hs_cnt + 1 : 0;
		ls_cnt = ls_en_in ? ls_cnt + 1 : 0;
		hs_ready_out <= hs_cnt > (slow_in ? 40 : 2);
		ls_ready_out <= ls_cnt > (slow_in ? 40 : 2);
	end
endmodule

// *** test/operating_mode_power_controller_test.sv ***
// Purpose: directed test of clock switching, halt modes and wake-up
// Assumes: inputs driven at falling edge, outputs read there
// Notes: oscillators come from osc_model
`timescale 1ns/100ps
module operating_mode_power_controller_test;
	logic clk_sys_in = 1'b0;
	logic resetn_in = 1'b0;
	logic halt_in = 1'b0, wdt_clear_instr_in = 1'b0, stack_full_in = 1'b0;
	logic [2:0] sysclk_select_in = 3'h0;
	logic hs_osc_idle_enable_in = 1'b0, ls_osc_idle_enable_in = 1'b0, hs_osc_enable_in = 1'b1;
	logic [1:0] hs_freq_select_in = 2'h0;
	logic wdt_enable_in = 1'b1, wdt_overflow_in = 1'b0, osc_slow = 1'b0;
	logic hs_osc_ready_in, ls_osc_ready_in;
	logic [7:0] porta_in = 8'hff, porta_wake_mask_in = 8'h01;
	logic [7:0] irq_request_in = 8'h00, irq_enable_in = 8'h00;
	logic sysclk_use_sub_out, hs_osc_en_out, ls_osc_en_out, hs_clk_run_out, sub_clk_run_out;
	logic cpu_run_out, hs_osc_stable_flag_out, powerdown_flag_out, wdt_timeout_flag_out;
	logic wdt_counter_clear_out, wake_resume_out, wake_irq_response_out, pc_sp_reset_out;
	logic [2:0] sysclk_div_sel_out;
	logic [1:0] hs_freq_out;
	logic [3:0] op_state_out;
	int failures = 0, checks_done = 0;
	logic [3:0] mode_of [4] = '{4'h4, 4'h5, 4'h7, 4'h6};
	logic [2:0] wake_of [4] = '{3'h1, 3'h2, 3'h1, 3'h4};
	wire logic [4:0] obs = {hs_osc_stable_flag_out, op_state_out};

	// clock
	always #50 clk_sys_in = ~clk_sys_in;

	operating_mode_power_controller dut (.clk_sys_in, .resetn_in, .halt_in, .wdt_clear_instr_in,
		.stack_full_in, .sysclk_select_in, .hs_osc_idle_enable_in, .ls_osc_idle_enable_in,
		.hs_osc_enable_in, .hs_freq_select_in, .wdt_enable_in, .hs_osc_ready_in, .ls_osc_ready_in,
		.porta_in, .porta_wake_mask_in, .irq_request_in, .irq_enable_in, .wdt_overflow_in,
		.sysclk_use_sub_out, .sysclk_div_sel_out, .hs_freq_out, .hs_osc_en_out, .ls_osc_en_out,
		.hs_clk_run_out, .sub_clk_run_out, .cpu_run_out, .hs_osc_stable_flag_out,
		.powerdown_flag_out, .wdt_timeout_flag_out, .wdt_counter_clear_out, .wake_resume_out,
		.wake_irq_response_out, .pc_sp_reset_out, .op_state_out);

	osc_model u_osc (.clk_sys_in, .hs_en_in(hs_osc_en_out), .ls_en_in(ls_osc_en_out),
		.slow_in(osc_slow), .hs_ready_out(hs_osc_ready_in), .ls_ready_out(ls_osc_ready_in));

	task automatic conclude();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge clk_sys_in);
	endtask

	// bounded wait until masked stable flag and state match
	task automatic waitv(input logic [4:0] m, input logic [4:0] v, input int lim);
		for (int i = 0; i < lim && (obs & m) !== v; i++) tick(1);
		if ((obs & m) !== v) begin
			chk("wait", 8'(v), 8'(obs & m));
			conclude();
		end
	endtask

	// halt with idle pair, then look at entry
	task automatic do_halt(input logic [1:0] p);
		{hs_osc_idle_enable_in, ls_osc_idle_enable_in} = p;
		halt_in = 1'b1;
		tick(1);
		halt_in = 1'b0;
		chk("mode", 8'(mode_of[p]), 8'(op_state_out));
		chk("sub clk", 8'(p[0]), 8'(sub_clk_run_out));
		chk("cpu run", 8'h00, 8'(cpu_run_out));
		chk("halt flags", 8'h05, {5'h00, powerdown_flag_out, wdt_timeout_flag_out,
			wdt_counter_clear_out});
		chk("ls osc", 8'(p[0] | wdt_enable_in), 8'(ls_osc_en_out));
	endtask

	// main sequence
	initial begin
		int p;
		tick(4);
		chk("reset", 8'h01, {op_state_out, powerdown_flag_out, wdt_timeout_flag_out,
			hs_osc_stable_flag_out, cpu_run_out});
		resetn_in = 1'b1;
		waitv(5'h10, 5'h10, 400);
		hs_freq_select_in = 2'h2;
		tick(1);
		chk("stable drop", 8'h00, 8'(hs_osc_stable_flag_out));
		tick(150);
		chk("freq hold", 8'h00, {5'h00, hs_osc_stable_flag_out, hs_freq_out});
		waitv(5'h10, 5'h10, 30);
		tick(2);
		chk("freq new", 8'h06, {5'h00, hs_clk_run_out, hs_freq_out});
		for (p = 0; p < 7; p++) begin
			sysclk_select_in = p[2:0];
			tick(2);
			chk("divider", 8'(p), {4'h0, sysclk_use_sub_out, sysclk_div_sel_out});
		end
		sysclk_select_in = 3'h7;
		tick(1);
		chk("to slow", 8'h01, 8'(op_state_out));
		waitv(5'h0f, 5'h02, 20);
		chk("use sub", 8'h01, 8'(sysclk_use_sub_out));
		hs_osc_enable_in = 1'b0;
		osc_slow = 1'b1;
		tick(5);
		chk("hs off", 8'h00, {5'h00, hs_clk_run_out, hs_osc_en_out, hs_osc_stable_flag_out});
		do_halt(2'h3);
		irq_enable_in = 8'h01;
		irq_request_in = 8'h01;
		waitv(5'h04, 5'h00, 10);
		chk("slow wake", {4'h2, 1'b0, wake_of[1]}, {op_state_out, 1'b0, pc_sp_reset_out,
			wake_irq_response_out, wake_resume_out});
		irq_request_in = 8'h00;
		sysclk_select_in = 3'h3;
		tick(1);
		chk("to fast", 8'h03, {3'h0, hs_osc_stable_flag_out, op_state_out});
		waitv(5'h0f, 5'h00, 400);
		chk("fast div", 8'h03, 8'(sysclk_div_sel_out));
		hs_osc_enable_in = 1'b1;
		for (p = 0; p < 4; p++) begin
			wdt_enable_in = (p != 2);
			irq_request_in = (p == 2) ? 8'h02 : 8'h00;
			do_halt(p[1:0]);
			porta_in = 8'hfd;
			tick(10);
			chk("no wake", 8'(mode_of[p]), 8'(op_state_out));
			case (p)
				0: porta_in = 8'hfc;
				1: irq_request_in = 8'h01;
				2: begin
					irq_request_in = 8'h06;
					stack_full_in = 1'b1;
				end
				default: wdt_overflow_in = 1'b1;
			endcase
			tick(1);
			wdt_overflow_in = 1'b0;
			waitv(5'h04, 5'h00, 10);
			chk("wake kind", 8'(wake_of[p]), {5'h00, pc_sp_reset_out, wake_irq_response_out,
				wake_resume_out});
			chk("tof", 8'(p == 3), 8'(wdt_timeout_flag_out));
			chk("pdf kept", 8'h01, 8'(powerdown_flag_out));
			irq_request_in = 8'h00;
			stack_full_in = 1'b0;
			porta_in = 8'hff;
			wdt_clear_instr_in = 1'b1;
			tick(1);
			wdt_clear_instr_in = 1'b0;
			chk("pdf clear", 8'h00, 8'(powerdown_flag_out));
			waitv(5'h0f, 5'h00, 400);
		end
		conclude();
	end
endmodule
